// ===== rtl/swc_regs.svh
// register offsets, field positions, reset values and timing counts of the power-off unit
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH

// register offsets (byte addresses)
`define SWC_OFS_CMD 8'h00
`define SWC_OFS_CFG 8'h04
`define SWC_OFS_STAT 8'h08
`define SWC_OFS_IRQ_STAT 8'h0c
`define SWC_OFS_IRQ_MASK 8'h10

// command register fields
`define SWC_KEY_LSB 24
`define SWC_KEY_MSB 31
`define SWC_KEY_VALUE 8'ha5
`define SWC_CMD_BIT 0

// configuration register fields
`define SWC_MODE_LSB 0
`define SWC_MODE_MSB 1
`define SWC_CNT0_LSB 4
`define SWC_ALARM_EN_BIT 16
`define SWC_CFG_RESET 32'h0000_0303
`define SWC_CFG_WMASK 32'h0001_f3f3

// status and interrupt register fields
`define SWC_ST_WAKE_BIT 0
`define SWC_ST_ALARM_BIT 1
`define SWC_STAT_RESET 2'h0
`define SWC_IRQ_RESET 2'h0

// timing counts in clock cycles
`define SWC_CMD_DELAY 2
`define SWC_DBN_UNIT 16
// debounce count starts at two: the wake synchroniser already spent that much,
// so the pin drops count*16+1 cycles after the first edge that sees the change, three cycles at count zero
`define SWC_DBN_START 2

`endif

// ===== rtl/swc_pkg.sv
// types shared by the power-off unit modules
package swc_pkg;

  // wake edge selection codes
  typedef enum logic [1:0] {
    WM_NONE = 2'b00,
    WM_RISE = 2'b01,
    WM_FALL = 2'b10,
    WM_BOTH = 2'b11
  } swc_wake_mode_type;

  // debounce counter states
  typedef enum logic {
    DBN_IDLE = 1'b0,
    DBN_COUNT = 1'b1
  } swc_dbn_state_type;

endpackage

// ===== rtl/swc_wake_filter.sv
// wake input synchroniser, edge selector and debounce counter
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"

module swc_wake_filter
  import swc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wake_i,
  input wire logic [1:0] mode_i,
  input wire logic [CNT_W-1:0] count_i,
  output logic fire_o
);

  localparam int UW = $clog2(`SWC_DBN_UNIT);
  localparam int CW = CNT_W + UW;

  // refuse widths the counter cannot serve
  initial begin
    if (CNT_W < 1 || CNT_W > 16) begin
      $error("swc_wake_filter: CNT_W out of range");
    end
  end

  logic sync_a_q; // first synchroniser stage
  logic sync_b_q; // second synchroniser stage
  logic prev_q; // previous synchronised level
  swc_dbn_state_type state_q, state_d;
  logic [CW-1:0] cyc_q, cyc_d; // cycles since qualifying change

  // edge decode on the synchronised level
  wire rise = sync_b_q & ~prev_q;
  wire fall = ~sync_b_q & prev_q;
  wire change = rise | fall;
  wire [1:0] mode = mode_i;
  // selected change, none when mode is 00
  wire sel = (mode == WM_RISE && rise) || (mode == WM_FALL && fall) ||
             (mode == WM_BOTH && change);
  // count is in units of sixteen cycles
  wire [CW-1:0] target = {count_i, {UW{1'b0}}};
  wire counting = (state_q == DBN_COUNT);
  wire reached = counting && !change && cyc_q >= target;

  assign fire_o = reached;

  // synchroniser and level history
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a_q <= 1'b0;
      sync_b_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync_a_q <= wake_i;
      sync_b_q <= sync_a_q;
      prev_q <= sync_b_q;
    end
  end

  // debounce state and counter next values
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    unique case (state_q)
      DBN_IDLE: begin
        if (sel) begin
          state_d = DBN_COUNT;
          cyc_d = CW'(`SWC_DBN_START);
        end
      end
      DBN_COUNT: begin
        if (change || reached || mode == WM_NONE) begin
          state_d = DBN_IDLE;
          cyc_d = '0;
        end else begin
          cyc_d = cyc_q + CW'(1);
        end
      end
    endcase
  end

  // debounce registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= DBN_IDLE;
      cyc_q <= '0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  short_pulse_a: assert property (counting && change |=> !counting && cyc_q == '0)
    else $error("debounce not cleared on new change");
  mode_off_a: assert property (mode == WM_NONE && !counting |=> !counting)
    else $error("debounce started while disabled");
  count_step_a: assert property (counting && !change && !reached && mode != WM_NONE
    |=> cyc_q == $past(cyc_q) + CW'(1))
    else $error("debounce counter did not advance");
  cov_filter_fire: cover property (counting ##1 fire_o);

endmodule
`default_nettype wire

// ===== rtl/swc_top.sv
// power-off unit: key-protected shutdown command, wake filtering, status and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"

// Contract
// - whole unit runs on free-running clock
// - command reaches pin two cycles later
// - write taken only with key a5
// - command bit one asserts, zero nothing
// - edge select: none, rise, fall, both
// - selected change starts sixteen-cycle-unit counter
// - counter at target releases power-off pin
// - new change stops and clears counter
// - release count times sixteen plus one, three at count zero
// - wake flag set on event, read-clear
// - synchronise alarm, detect its rising edge
// - enabled alarm releases pin, else ignored
// - enabled alarm sets read-clear alarm flag
module swc_top
  import swc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W = 4
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [31:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [31:0] RD_DATA,
  input wire logic WAKE_IN,
  input wire logic ALARM_IN,
  output logic PWR_OFF_PIN,
  output logic IRQ
);

  // refuse sizes the decode and field layout cannot serve
  initial begin
    if (ADDR_W < 5) begin
      $error("swc_top: ADDR_W too small for the map");
    end
    if (CNT_W != 4) begin
      $error("swc_top: CNT_W must match the 4-bit count field");
    end
  end

  // register state
  logic [31:0] cfg_q; // wake configuration
  logic wake_flag_q; // wake input flag, read-clear
  logic alarm_flag_q; // alarm wake flag, read-clear
  logic [1:0] irq_stat_q; // sticky interrupt status, write-one-clear
  logic [1:0] irq_mask_q; // interrupt mask
  logic [`SWC_CMD_DELAY-1:0] cmd_pipe_q; // accepted command delay line
  logic pwr_off_q; // power-off pin register
  logic [31:0] rd_data_q; // read data register
  logic irq_q; // interrupt output register

  // alarm synchroniser and edge history
  logic alarm_a_q; // first stage
  logic alarm_b_q; // second stage
  logic alarm_prev_q; // previous synchronised level

  // address decode
  wire hit_cmd = (ADDR == ADDR_W'(`SWC_OFS_CMD));
  wire hit_cfg = (ADDR == ADDR_W'(`SWC_OFS_CFG));
  wire hit_stat = (ADDR == ADDR_W'(`SWC_OFS_STAT));
  wire hit_ist = (ADDR == ADDR_W'(`SWC_OFS_IRQ_STAT));
  wire hit_imask = (ADDR == ADDR_W'(`SWC_OFS_IRQ_MASK));

  // command decode: a wrong key drops the whole write
  wire key_ok = (WR_DATA[`SWC_KEY_MSB:`SWC_KEY_LSB] == `SWC_KEY_VALUE);
  wire cmd_wr = WR_EN && hit_cmd;
  wire cmd_go = cmd_wr && key_ok && WR_DATA[`SWC_CMD_BIT];
  wire cmd_land = cmd_pipe_q[`SWC_CMD_DELAY-1];

  // configuration fields
  wire [1:0] wake_edge_select = cfg_q[`SWC_MODE_MSB:`SWC_MODE_LSB];
  wire [CNT_W-1:0] wake_debounce_count = cfg_q[`SWC_CNT0_LSB +: CNT_W];
  wire alarm_wake_enable = cfg_q[`SWC_ALARM_EN_BIT];

  // wake and alarm events
  logic wake_fire; // debounced wake event pulse
  wire alarm_rise = alarm_b_q & ~alarm_prev_q;
  wire alarm_go = alarm_rise & alarm_wake_enable;
  wire release_pin = wake_fire | alarm_go;

  // status read clears each flag unless that flag's own event lands in the same cycle
  wire stat_rd = RD_EN && hit_stat;
  wire [1:0] irq_event = {alarm_go, wake_fire};
  wire [1:0] irq_clr = (WR_EN && hit_ist) ? WR_DATA[1:0] : 2'h0;
  wire [1:0] irq_stat_d = irq_event | (irq_stat_q & ~irq_clr);
  wire irq_d = |(irq_stat_d & irq_mask_q);

  // read data selection, unmapped and write-only read as zero
  wire [31:0] stat_word = {30'h0, alarm_flag_q, wake_flag_q};
  wire [31:0] rd_mux = hit_cfg ? cfg_q :
                       hit_stat ? stat_word :
                       hit_ist ? {30'h0, irq_stat_q} :
                       hit_imask ? {30'h0, irq_mask_q} :
                       32'h0;

  // debounced wake detection on the one wake input
  swc_wake_filter #(
    .CNT_W(CNT_W)
  ) u_wake (
    .clk(CLK),
    .rst(RST),
    .wake_i(WAKE_IN),
    .mode_i(wake_edge_select),
    .count_i(wake_debounce_count),
    .fire_o(wake_fire)
  );

  // everything here sits on the one free-running clock, never gated
  // configuration register, masked to the defined bits
  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_q <= `SWC_CFG_RESET;
    end else if (WR_EN && hit_cfg) begin
      cfg_q <= WR_DATA & `SWC_CFG_WMASK;
    end
  end

  // accepted commands walk down the delay line
  always_ff @(posedge CLK) begin
    if (RST) begin
      cmd_pipe_q <= '0;
    end else begin
      cmd_pipe_q <= {cmd_pipe_q[`SWC_CMD_DELAY-2:0], cmd_go};
    end
  end

  // power-off pin: set by a landed command, held until a wake
  always_ff @(posedge CLK) begin
    if (RST) begin
      pwr_off_q <= 1'b0;
    end else if (cmd_land) begin
      pwr_off_q <= 1'b1;
    end else if (release_pin) begin
      pwr_off_q <= 1'b0;
    end
  end

  // alarm synchroniser and rising edge history
  always_ff @(posedge CLK) begin
    if (RST) begin
      alarm_a_q <= 1'b0;
      alarm_b_q <= 1'b0;
      alarm_prev_q <= 1'b0;
    end else begin
      alarm_a_q <= ALARM_IN;
      alarm_b_q <= alarm_a_q;
      alarm_prev_q <= alarm_b_q;
    end
  end

  // read-clear status flags, set wins over the clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      {alarm_flag_q, wake_flag_q} <= `SWC_STAT_RESET;
    end else begin
      wake_flag_q <= wake_fire | (wake_flag_q & ~stat_rd);
      alarm_flag_q <= alarm_go | (alarm_flag_q & ~stat_rd);
    end
  end

  // sticky interrupt status and mask
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat_q <= `SWC_IRQ_RESET;
      irq_mask_q <= `SWC_IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (WR_EN && hit_imask) begin
        irq_mask_q <= WR_DATA[1:0];
      end
    end
  end

  // interrupt level and read data registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_q <= 1'b0;
      rd_data_q <= 32'h0;
    end else begin
      irq_q <= irq_d;
      rd_data_q <= RD_EN ? rd_mux : 32'h0;
    end
  end

  // outputs straight from flip-flops
  assign PWR_OFF_PIN = pwr_off_q;
  assign RD_DATA = rd_data_q;
  assign IRQ = irq_q;

  // the wake edge on the timer alarm needs the alarm low before shutdown

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  cmd_delay_a: assert property (cmd_go && !PWR_OFF_PIN && !release_pin && !cmd_land
    && !cmd_pipe_q[0] |=> !PWR_OFF_PIN ##1 !PWR_OFF_PIN ##1 PWR_OFF_PIN)
    else $error("command did not reach the pin two cycles later");
  bad_key_a: assert property (cmd_wr && !key_ok |=> !cmd_pipe_q[0])
    else $error("write with wrong key was accepted");
  zero_cmd_a: assert property (cmd_wr && !WR_DATA[`SWC_CMD_BIT] |=> !cmd_pipe_q[0])
    else $error("zero command bit started a shutdown");
  pin_hold_a: assert property (PWR_OFF_PIN && !release_pin |=> PWR_OFF_PIN)
    else $error("power-off pin dropped without a wake");
  wake_release_a: assert property (wake_fire && !cmd_land |=> !PWR_OFF_PIN)
    else $error("debounced wake did not release the pin");
  alarm_release_a: assert property (alarm_rise && alarm_wake_enable && !cmd_land
    |=> !PWR_OFF_PIN && alarm_flag_q)
    else $error("enabled alarm did not release the pin");
  alarm_ignored_a: assert property (alarm_rise && !alarm_wake_enable && !wake_flag_q
    && !alarm_flag_q && !wake_fire |=> !alarm_flag_q)
    else $error("disabled alarm was recorded");
  wake_flag_a: assert property (stat_rd && !wake_fire |=> !wake_flag_q)
    else $error("wake flag not cleared by status read");
  wake_set_a: assert property (wake_fire |=> wake_flag_q)
    else $error("wake flag not set by wake event");
  alarm_edge_a: assert property ($rose(ALARM_IN) ##1 ALARM_IN ##1 ALARM_IN
    |-> alarm_rise)
    else $error("alarm rising edge not seen after synchronising");
  wake_delay_a: assert property (wake_fire && wake_debounce_count != '0
    |-> $past(u_wake.state_q) == DBN_COUNT)
    else $error("wake fired without a debounce period");
  irq_level_a: assert property (IRQ == $past(irq_d))
    else $error("interrupt output does not follow masked status");

  cov_cmd: cover property (cmd_go ##3 PWR_OFF_PIN);
  cov_wake: cover property (PWR_OFF_PIN && wake_fire ##1 !PWR_OFF_PIN);
  cov_alarm: cover property (PWR_OFF_PIN && alarm_go ##1 !PWR_OFF_PIN);
  cov_irq: cover property (IRQ && irq_clr != 2'h0);

endmodule
`default_nettype wire

// ===== tb/swc_far_side.sv
// far-side model: wake push-button, timer alarm line and supply converter
`timescale 1ns/1ps
`default_nettype none

module swc_far_side (
  input wire logic clk,
  input wire logic pwr_off,
  input wire logic toggle_req,
  input wire logic [7:0] glitch_len,
  input wire logic alarm_req,
  output logic wake,
  output logic alarm,
  output logic supply_on
);
  logic [7:0] left_q; // cycles until a glitch springs back

  // button and alarm start low
  initial begin
    wake = 1'b0;
    alarm = 1'b0;
    left_q = 8'h00;
  end

  // button: a press flips the level, a glitch flips it back later
  always @(posedge clk) begin
    if (toggle_req) begin
      wake <= ~wake;
      left_q <= glitch_len;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
      if (left_q == 8'h01) begin
        wake <= ~wake;
      end
    end
  end

  // alarm follows the timer side, which drops it before any shutdown
  always @(posedge clk) begin
    alarm <= alarm_req;
  end

  // converter supplies power while not told to shut down
  assign supply_on = ~pwr_off;
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the power-off unit with random and corner stimulus
`timescale 1ns/1ps
`default_nettype none
`include "swc_regs.svh"

module testbench;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic WR_EN = 1'b0;
  logic RD_EN = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WR_DATA = 32'h0;
  logic [31:0] RD_DATA, rd_val, w;
  logic [31:0] seed = 32'h9daa565b;
  logic PWR_OFF_PIN, IRQ, WAKE_IN, ALARM_IN;
  logic tog = 1'b0;
  logic alarm_req = 1'b0;
  logic [7:0] glen = 8'h00;
  logic [3:0] c;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;

  swc_top #(.ADDR_W(8), .CNT_W(4)) uut (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
    .WAKE_IN(WAKE_IN), .ALARM_IN(ALARM_IN), .PWR_OFF_PIN(PWR_OFF_PIN), .IRQ(IRQ));
  swc_far_side far (.clk(CLK), .pwr_off(PWR_OFF_PIN), .toggle_req(tog),
    .glitch_len(glen), .alarm_req(alarm_req), .wake(WAKE_IN), .alarm(ALARM_IN),
    .supply_on());

  // 125 MHz clock and hang guard
  always #4 CLK = ~CLK;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      wrap_up();
    end
  end

  // xorshift random source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // configuration word from its fields
  function automatic logic [31:0] cfg(logic [1:0] m, logic [3:0] k, logic en);
    return {15'h0, en, 8'h0, k, 2'h0, m};
  endfunction

  task automatic cmp_w(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_b(string what, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge CLK);
    WR_EN <= 1'b1;
    ADDR <= a;
    WR_DATA <= d;
    @(posedge CLK);
    WR_EN <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge CLK);
    RD_EN <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD_EN <= 1'b0;
    #1 rd_val = RD_DATA;
  endtask

  task automatic waitc(int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask

  // button press, springing back after len cycles unless len is zero
  task automatic toggle(logic [7:0] len);
    @(posedge CLK);
    tog <= 1'b1;
    glen <= len;
    @(posedge CLK);
    tog <= 1'b0;
  endtask

  // keyed shutdown command and its two-cycle delay
  // pre is the pin level that must still stand one edge after the write
  task automatic arm(logic pre);
    wr(`SWC_OFS_CMD, {`SWC_KEY_VALUE, 24'h1});
    waitc(1);
    cmp_b("pin one edge after command", pre, PWR_OFF_PIN);
    waitc(1);
    cmp_b("pin two edges after command", 1'b1, PWR_OFF_PIN);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    waitc(1);
    cmp_b("pin after reset", 1'b0, PWR_OFF_PIN);
    rd(`SWC_OFS_CFG);
    cmp_w("config reset", `SWC_CFG_RESET, rd_val);
    rd(`SWC_OFS_STAT);
    cmp_w("status reset", 32'h0, rd_val);
    rd(`SWC_OFS_CMD);
    cmp_w("command readback", 32'h0, rd_val);
    rd(8'h14);
    cmp_w("unmapped read", 32'h0, rd_val);
    for (n = 0; n < 4; n++) begin
      w = xs();
      wr(`SWC_OFS_CFG, w);
      rd(`SWC_OFS_CFG);
      cmp_w("config readback", w & `SWC_CFG_WMASK, rd_val);
    end
    $display("test registers done");
    wr(`SWC_OFS_CFG, cfg(2'b00, 4'h1, 1'b0));
    for (n = 0; n < 4; n++) begin
      w = xs() | 32'h1;
      if (w[31:24] == 8'ha5) begin
        w[31:24] = 8'h5a;
      end
      wr(`SWC_OFS_CMD, w);
      waitc(3);
      cmp_b("pin after wrong key", 1'b0, PWR_OFF_PIN);
    end
    wr(`SWC_OFS_CMD, {`SWC_KEY_VALUE, 24'h0});
    waitc(3);
    cmp_b("pin after zero command", 1'b0, PWR_OFF_PIN);
    arm(1'b0);
    toggle(8'h00);
    waitc(40);
    cmp_b("pin with detection off", 1'b1, PWR_OFF_PIN);
    wr(`SWC_OFS_CFG, cfg(2'b01, 4'h1, 1'b0));
    toggle(8'h00);
    waitc(40);
    cmp_b("pin after unselected edge", 1'b1, PWR_OFF_PIN);
    $display("test command done");
    for (n = 1; n < 4; n++) begin
      w = xs();
      c = {2'b00, w[1:0]} + 4'h1;
      wr(`SWC_OFS_CFG, cfg(n[1:0], c, 1'b0));
      arm(n == 1);
      toggle(8'(2 + (w[15:8] % (16 * c - 4))));
      waitc(16 * c + 2);
      cmp_b("pin after short pulse", 1'b1, PWR_OFF_PIN);
      waitc(16 * c + 4);
      rd(`SWC_OFS_STAT);
      arm(1'b1);
      toggle(8'h00);
      waitc(16 * c + 1);
      cmp_b("pin just before release", 1'b1, PWR_OFF_PIN);
      waitc(1);
      cmp_b("pin at release", 1'b0, PWR_OFF_PIN);
      rd(`SWC_OFS_STAT);
      cmp_w("wake flag", 32'h1, rd_val);
      rd(`SWC_OFS_STAT);
      cmp_w("wake flag after read", 32'h0, rd_val);
    end
    $display("test wake done");
    wr(`SWC_OFS_IRQ_STAT, 32'h3);
    wr(`SWC_OFS_IRQ_MASK, 32'h2);
    arm(1'b0);
    @(posedge CLK);
    alarm_req <= 1'b1;
    waitc(6);
    cmp_b("pin with alarm disabled", 1'b1, PWR_OFF_PIN);
    rd(`SWC_OFS_STAT);
    cmp_w("alarm flag disabled", 32'h0, rd_val);
    @(posedge CLK);
    alarm_req <= 1'b0;
    wr(`SWC_OFS_CFG, cfg(2'b00, 4'h1, 1'b1));
    @(posedge CLK);
    alarm_req <= 1'b1;
    waitc(3);
    cmp_b("pin before alarm release", 1'b1, PWR_OFF_PIN);
    waitc(1);
    cmp_b("pin after alarm", 1'b0, PWR_OFF_PIN);
    waitc(2);
    cmp_b("interrupt raised", 1'b1, IRQ);
    rd(`SWC_OFS_STAT);
    cmp_w("alarm flag", 32'h2, rd_val);
    rd(`SWC_OFS_IRQ_STAT);
    cmp_w("interrupt status", 32'h2, rd_val);
    wr(`SWC_OFS_IRQ_STAT, 32'h2);
    waitc(2);
    cmp_b("interrupt cleared", 1'b0, IRQ);
    $display("test alarm done");
    wrap_up();
  end
endmodule

`default_nettype wire
